// ===== rtl/nco_pkg.sv
// constants, register map and state types for the numeric oscillator
package nco_pkg;

  localparam int ACC_W = 20;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 6;
  localparam int BUS_W = 32;
  localparam int CNT_W = 8;
  localparam int NUM_SRC_DEF = 11;

  // byte addresses on the register bus, one word per register
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_CLOCK = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_ACC_LOW = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_ACC_HIGH = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_ACC_UPPER = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_STEP_LOW = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_STEP_HIGH = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_STEP_UPPER = 6'h1C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 6'h24;

  // control register fields
  localparam int BIT_ENABLE = 7;
  localparam int BIT_OUT = 5;
  localparam int BIT_INVERT = 4;
  localparam int BIT_PULSE_MODE = 0;
  // clock register fields
  localparam int PWS_LSB = 5;
  localparam int PWS_MSB = 7;
  localparam int CKS_LSB = 0;
  localparam int CKS_MSB = 3;
  localparam logic [BYTE_W-1:0] CLOCK_WR_MASK = 8'hEF;
  // upper bytes hold four bits
  localparam int UPPER_W = ACC_W - 2 * BYTE_W;
  // interrupt status and mask
  localparam int BIT_IRQ_OVF = 0;

  localparam logic [BYTE_W-1:0] RST_CLOCK = 8'h00;
  localparam logic [ACC_W-1:0] RST_ACC = 20'h0_0000;
  localparam logic [ACC_W-1:0] RST_STEP = 20'h0_0001;
  localparam logic [CNT_W-1:0] RST_COUNT = 8'h00;

  typedef struct packed {
    logic en;
    logic invert;
    logic pulse_mode;
  } osc_ctrl_t;

  typedef struct packed {
    logic active;
    logic [CNT_W-1:0] count;
  } pulse_state_t;

  typedef struct packed {
    osc_ctrl_t ctrl;
    logic [BYTE_W-1:0] clk_cfg;
    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] step;
    logic [ACC_W-1:0] shadow;
    logic load_pending;
    logic src_prev;
    logic carry;
    logic toggle_level;
    logic out_level;
    logic irq_status;
    logic irq_mask;
    logic irq;
    logic waitreq;
    logic [BYTE_W-1:0] rdata;
  } nco_state_t;

endpackage

// ===== rtl/nco_pulse_stretch.sv
// pulse stretcher that holds the pulse-mode output for a chosen width
`timescale 1ns/10ps
`default_nettype none
module nco_pulse_stretch
  import nco_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic tick,
  input wire logic clear,
  input wire logic [PWS_MSB-PWS_LSB:0] width_code,
  output logic active
);

  pulse_state_t s;
  pulse_state_t n;

  // periods minus one; code 0 gives a single period
  function automatic logic [CNT_W-1:0] width_less_one(input logic [PWS_MSB-PWS_LSB:0] code);
    logic [CNT_W-1:0] one;
    one = 8'h01;
    return (one << code) - one;
  endfunction

  always_comb begin
    n = s;
    if (clear) begin
      n.active = 1'b0;
      n.count = RST_COUNT;
    end else if (start) begin
      // retrigger restarts the width, so an over-long width never drops the output
      n.active = 1'b1;
      n.count = width_less_one(width_code);
    end else if (tick && s.active) begin
      if (s.count == RST_COUNT) begin
        n.active = 1'b0;
      end else begin
        n.count = s.count - 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign active = s.active;

endmodule // nco_pulse_stretch
`default_nettype wire

// ===== rtl/numeric_oscillator_regs.sv
// numerically controlled oscillator with its byte registers on Avalon-MM
`timescale 1ns/10ps
`default_nettype none
module numeric_oscillator_regs
  import nco_pkg::*;
#(
  parameter int NUM_SRC = NUM_SRC_DEF
) (
  input wire logic core_clk,
  input wire logic rst_n,
  // source clocks, sampled as ordinary levels on core_clk
  input wire logic [NUM_SRC-1:0] src_clks,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [BUS_W-1:0] writedata,
  input wire logic [BUS_W/BYTE_W-1:0] byteenable,
  output logic [BUS_W-1:0] readdata,
  output logic waitrequest,
  output logic osc_output_level,
  output logic accumulator_carry_out,
  output logic irq
);

  nco_state_t s;
  nco_state_t n;
  logic pulse_active;
  logic pulse_start;
  logic pulse_tick;
  logic pulse_clear;

  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
    return addr == ofs;
  endfunction

  function automatic logic [BYTE_W-1:0] upper_byte(input logic [ACC_W-1:0] v);
    // unused upper bits always read as zero
    return {{(BYTE_W-UPPER_W){1'b0}}, v[ACC_W-1:2*BYTE_W]};
  endfunction

  function automatic logic [BYTE_W-1:0] read_mux(input nco_state_t st,
                                                 input logic [ADDR_W-1:0] addr);
    logic [BYTE_W-1:0] v;
    v = '0;
    if (hit(addr, OFS_CONTROL)) begin
      v[BIT_ENABLE] = st.ctrl.en;
      v[BIT_OUT] = st.out_level;
      v[BIT_INVERT] = st.ctrl.invert;
      v[BIT_PULSE_MODE] = st.ctrl.pulse_mode;
    end else if (hit(addr, OFS_CLOCK)) begin
      v = st.clk_cfg & CLOCK_WR_MASK;
    end else if (hit(addr, OFS_ACC_LOW)) begin
      // live view; bytes taken in separate reads may straddle a carry
      v = st.acc[BYTE_W-1:0];
    end else if (hit(addr, OFS_ACC_HIGH)) begin
      v = st.acc[2*BYTE_W-1:BYTE_W];
    end else if (hit(addr, OFS_ACC_UPPER)) begin
      v = upper_byte(st.acc);
    end else if (hit(addr, OFS_STEP_LOW)) begin
      v = st.step[BYTE_W-1:0];
    end else if (hit(addr, OFS_STEP_HIGH)) begin
      v = st.step[2*BYTE_W-1:BYTE_W];
    end else if (hit(addr, OFS_STEP_UPPER)) begin
      v = upper_byte(st.step);
    end else if (hit(addr, OFS_IRQ_STATUS)) begin
      v[BIT_IRQ_OVF] = st.irq_status;
    end else if (hit(addr, OFS_IRQ_MASK)) begin
      v[BIT_IRQ_OVF] = st.irq_mask;
    end
    return v;
  endfunction

  nco_pulse_stretch u_pulse (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .start(pulse_start),
    .tick(pulse_tick),
    .clear(pulse_clear),
    .width_code(s.clk_cfg[PWS_MSB:PWS_LSB]),
    .active(pulse_active)
  );

  logic [CKS_MSB-CKS_LSB:0] sel;
  logic src_now;
  logic rise;
  logic fall;
  logic carry;
  logic [ACC_W-1:0] sum;
  logic req;
  logic wr_go;
  logic rd_go;
  logic [BYTE_W-1:0] wd;

  always_comb begin
    // source selection; codes past the last source select a stopped clock
    sel = s.clk_cfg[CKS_MSB:CKS_LSB];
    src_now = 1'b0;
    if (int'(sel) < NUM_SRC) begin
      src_now = src_clks[sel];
    end
    rise = src_now && !s.src_prev;
    fall = !src_now && s.src_prev;
    {carry, sum} = {1'b0, s.acc} + {1'b0, s.shadow};
    carry = carry && s.ctrl.en && rise;
    pulse_start = carry && s.ctrl.pulse_mode;
    pulse_tick = rise && s.ctrl.en;
    pulse_clear = !s.ctrl.en || !s.ctrl.pulse_mode;
  end

  always_comb begin
    n = s;
    req = read || write;
    wd = writedata[BYTE_W-1:0];
    wr_go = write && !s.waitreq && byteenable[0];
    rd_go = read && !s.waitreq;
    n.src_prev = src_now;

    // one wait cycle per access, then a one-cycle answer
    n.waitreq = !(req && s.waitreq);
    if (req && s.waitreq) begin
      n.rdata = read_mux(s, address);
    end

    n.carry = carry;
    if (s.ctrl.en && rise) begin
      n.acc = sum;
    end
    if (carry) begin
      n.toggle_level = !s.toggle_level;
    end

    // shadow follows the step registers on a source falling edge, or at once when off
    if (s.load_pending && (!s.ctrl.en || fall)) begin
      n.shadow = s.step;
      n.load_pending = 1'b0;
    end

    if (wr_go) begin
      if (hit(address, OFS_CONTROL)) begin
        n.ctrl.en = wd[BIT_ENABLE];
        n.ctrl.invert = wd[BIT_INVERT];
        n.ctrl.pulse_mode = wd[BIT_PULSE_MODE];
      end else if (hit(address, OFS_CLOCK)) begin
        n.clk_cfg = wd & CLOCK_WR_MASK;
      end else if (hit(address, OFS_ACC_LOW)) begin
        // a write while running overrides this byte of the adder result; the other bytes still take the sum
        n.acc[BYTE_W-1:0] = wd;
      end else if (hit(address, OFS_ACC_HIGH)) begin
        n.acc[2*BYTE_W-1:BYTE_W] = wd;
      end else if (hit(address, OFS_ACC_UPPER)) begin
        n.acc[ACC_W-1:2*BYTE_W] = wd[UPPER_W-1:0];
      end else if (hit(address, OFS_STEP_LOW)) begin
        // only the low byte arms the transfer, so write it last
        n.step[BYTE_W-1:0] = wd;
        n.load_pending = 1'b1;
      end else if (hit(address, OFS_STEP_HIGH)) begin
        n.step[2*BYTE_W-1:BYTE_W] = wd;
      end else if (hit(address, OFS_STEP_UPPER)) begin
        n.step[ACC_W-1:2*BYTE_W] = wd[UPPER_W-1:0];
      end else if (hit(address, OFS_IRQ_MASK)) begin
        n.irq_mask = wd[BIT_IRQ_OVF];
      end
    end

    // read of status clears it; a same-cycle overflow still sets it
    if (rd_go && hit(address, OFS_IRQ_STATUS)) begin
      n.irq_status = 1'b0;
    end
    if (carry) begin
      n.irq_status = 1'b1;
    end
    n.irq = n.irq_status && n.irq_mask;

    if (s.ctrl.pulse_mode) begin
      n.out_level = pulse_active ^ s.ctrl.invert;
    end else begin
      n.out_level = n.toggle_level ^ s.ctrl.invert;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s <= '0;
      s.clk_cfg <= RST_CLOCK;
      s.acc <= RST_ACC;
      s.step <= RST_STEP;
      s.shadow <= RST_STEP;
      s.waitreq <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign readdata = {{(BUS_W-BYTE_W){1'b0}}, s.rdata};
  assign waitrequest = s.waitreq;
  assign osc_output_level = s.out_level;
  assign accumulator_carry_out = s.carry;
  assign irq = s.irq;

endmodule // numeric_oscillator_regs
`default_nettype wire

// ===== tb/numeric_oscillator_regs_assertions.sv
// concurrent checks on the oscillator register block ports
`timescale 1ns/10ps
`default_nettype none
module nco_regs_check
  import nco_pkg::*;
#(
  parameter int NUM_SRC = NUM_SRC_DEF
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [NUM_SRC-1:0] src_clks,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [BUS_W-1:0] writedata,
  input wire logic [BUS_W/BYTE_W-1:0] byteenable,
  input wire logic [BUS_W-1:0] readdata,
  input wire logic waitrequest,
  input wire logic osc_output_level,
  input wire logic accumulator_carry_out,
  input wire logic irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire logic bus_act = read || write;
  wire logic up_rd = read && (address == OFS_ACC_UPPER || address == OFS_STEP_UPPER);
  a_wait_short: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low too long");
  a_idle_wait: assert property (!bus_act |=> waitrequest)
    else $error("answer without request");
  a_req_answered: assert property (bus_act && waitrequest |=> !waitrequest)
    else $error("access not answered");
  a_upper_pad: assert property (up_rd && !waitrequest |-> readdata[7:4] == 4'h0)
    else $error("upper byte pad not zero");
  a_read_pad: assert property (read && !waitrequest |-> readdata[31:8] == 24'h00_0000)
    else $error("read pad not zero");
  a_carry_single: assert property (accumulator_carry_out |=> !accumulator_carry_out)
    else $error("carry pulse too long");
  a_reset_outputs: assert property ($rose(rst_n) |-> waitrequest && !irq && !osc_output_level)
    else $error("outputs not cleared by reset");
  a_irq_cause: assert property ($rose(irq) |->
    accumulator_carry_out || $past(write) || $past(write, 2))
    else $error("irq rose without overflow");
  a_irq_clear: assert property ($fell(irq) |-> $past(bus_act) || $past(bus_act, 2))
    else $error("irq dropped without access");
  c_carry: cover property (accumulator_carry_out);
  c_irq: cover property ($rose(irq));
  c_read: cover property (read && !waitrequest);
endmodule // nco_regs_check
bind numeric_oscillator_regs nco_regs_check #(.NUM_SRC(NUM_SRC)) chk_i (
  .core_clk(core_clk), .rst_n(rst_n), .src_clks(src_clks), .address(address),
  .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
  .readdata(readdata), .waitrequest(waitrequest), .osc_output_level(osc_output_level),
  .accumulator_carry_out(accumulator_carry_out), .irq(irq));
`default_nettype wire

// ===== tb/numeric_oscillator_regs_test.sv
// self-checking bench for the oscillator register block
`timescale 1ns/10ps
`default_nettype none
module numeric_oscillator_regs_test
  import nco_pkg::*;
;
  localparam int NS = 11;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [NS-1:0] src_clks = '0;
  logic [ADDR_W-1:0] address = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [BUS_W-1:0] writedata = '0;
  logic [BUS_W/BYTE_W-1:0] byteenable = 4'hF;
  logic [BUS_W-1:0] readdata;
  logic waitrequest, osc_output_level, accumulator_carry_out, irq;
  int err_count = 0;
  int samples_checked = 0;
  // overflow pulses counted as they stand, checked against the expected total
  int carry_seen = 0;
  always @(posedge core_clk) begin
    if (accumulator_carry_out === 1'b1) begin
      carry_seen <= carry_seen + 1;
    end
  end
  numeric_oscillator_regs #(.NUM_SRC(NS)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .src_clks(src_clks), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .osc_output_level(osc_output_level),
    .accumulator_carry_out(accumulator_carry_out), .irq(irq));
  initial forever #50 core_clk = ~core_clk;
  task automatic xfer(input logic [ADDR_W-1:0] a, input logic w, input logic [7:0] d,
                      output logic [7:0] q);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= {24'h00_0000, d};
    do @(posedge core_clk); while (waitrequest !== 1'b0);
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    logic [7:0] q;
    xfer(a, 1'b0, 8'h00, q);
    chk($sformatf("reg %h", a), e, q);
  endtask
  // sampled mid-cycle so registered outputs have settled, then back on the rising edge
  task automatic bit_chk(input string n, input logic e, ref logic g);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    samples_checked++;
    if (g !== e) begin
      $display("[ERR] %s expected %b seen %b", n, e, g);
      err_count++;
    end
    @(posedge core_clk);
  endtask
  // source clock stands still between pulses
  task automatic pulse(input logic [NS-1:0] m, input int n);
    repeat (n) begin
      src_clks <= m;
      repeat (4) @(posedge core_clk);
      src_clks <= '0;
      repeat (4) @(posedge core_clk);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i <= 10; i++) begin
      rd(6'(i * 4), (i == 5) ? 8'h01 : 8'h00);
    end
    $display("reset test done");
    wr(OFS_STEP_UPPER, 8'hFF);
    rd(OFS_STEP_UPPER, 8'h0F);
    wr(OFS_ACC_UPPER, 8'hFF);
    rd(OFS_ACC_UPPER, 8'h0F);
    wr(OFS_ACC_UPPER, 8'h00);
    wr(OFS_CLOCK, 8'hFF);
    byteenable <= 4'h0;
    wr(OFS_CLOCK, 8'h00);
    byteenable <= 4'hF;
    rd(OFS_CLOCK, 8'hEF);
    wr(6'h28, 8'hFF);
    rd(6'h28, 8'h00);
    $display("access test done");
    wr(OFS_STEP_UPPER, 8'h08);
    wr(OFS_STEP_HIGH, 8'h00);
    wr(OFS_STEP_LOW, 8'h00);
    wr(OFS_IRQ_MASK, 8'h01);
    wr(OFS_CLOCK, 8'hE2);
    wr(OFS_CONTROL, 8'h80);
    pulse(11'h008, 2);
    rd(OFS_ACC_UPPER, 8'h00);
    pulse(11'h004, 1);
    rd(OFS_ACC_UPPER, 8'h08);
    pulse(11'h004, 1);
    bit_chk("irq", 1'b1, irq);
    bit_chk("output", 1'b1, osc_output_level);
    rd(OFS_CONTROL, 8'hA0);
    rd(OFS_IRQ_STATUS, 8'h01);
    rd(OFS_IRQ_STATUS, 8'h00);
    bit_chk("irq", 1'b0, irq);
    $display("toggle test done");
    wr(OFS_STEP_HIGH, 8'h40);
    wr(OFS_STEP_LOW, 8'h00);
    pulse(11'h004, 2);
    rd(OFS_ACC_HIGH, 8'h40);
    bit_chk("output", 1'b0, osc_output_level);
    wr(OFS_CONTROL, 8'h90);
    bit_chk("output", 1'b1, osc_output_level);
    $display("shadow test done");
    wr(OFS_CONTROL, 8'h00);
    wr(OFS_STEP_UPPER, 8'h04);
    wr(OFS_STEP_HIGH, 8'h00);
    wr(OFS_STEP_LOW, 8'h00);
    wr(OFS_ACC_HIGH, 8'h00);
    wr(OFS_CLOCK, 8'h22);
    wr(OFS_CONTROL, 8'h81);
    pulse(11'h004, 4);
    bit_chk("output", 1'b1, osc_output_level);
    pulse(11'h004, 1);
    bit_chk("output", 1'b1, osc_output_level);
    pulse(11'h004, 1);
    bit_chk("output", 1'b0, osc_output_level);
    wr(OFS_CLOCK, 8'h2F);
    pulse(11'h7FF, 2);
    rd(OFS_ACC_UPPER, 8'h08);
    chk("carry count", 8'h03, 8'(carry_seen));
    $display("pulse test done");
    // a reset in mid-run must bring control, step low, interrupt status and irq back
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(OFS_CONTROL, 8'h00);
    rd(OFS_STEP_LOW, 8'h01);
    rd(OFS_IRQ_STATUS, 8'h00);
    bit_chk("irq", 1'b0, irq);
    $display("second reset test done");
    close_out();
  end
endmodule // numeric_oscillator_regs_test
`default_nettype wire
